/* File: hw/fsb_pkg.sv */
// Purpose: Shared constants for the serial flash buffer program link.
// Assumes: 100 MHz system clock on both ends.
// Notes: Opcodes, address field positions, page sizes and timing counts.
package fsb_pkg;
   // ==========================================================
   // Opcodes
   localparam logic [7:0] OP_LOAD_B1 = 8'h84;
   localparam logic [7:0] OP_LOAD_B2 = 8'h87;
   localparam logic [7:0] OP_CMT_ERASE_B1 = 8'h83;
   localparam logic [7:0] OP_CMT_ERASE_B2 = 8'h86;
   localparam logic [7:0] OP_CMT_NOERASE_B1 = 8'h88;
   localparam logic [7:0] OP_CMT_NOERASE_B2 = 8'h89;
   localparam logic [7:0] OP_LOAD_CMT_B1 = 8'h82;
   localparam logic [7:0] OP_LOAD_CMT_B2 = 8'h85;
   // ==========================================================
   // Address layout and page sizes
   localparam int ADDR_BYTES = 3;
   localparam logic [2:0] DATA_PHASE = 3'h4;
   localparam int PAGE_BITS = 12;
   localparam int WIDE_PAGE_LSB = 9;
   localparam int NARROW_PAGE_LSB = 8;
   localparam int WIDE_START_BITS = 9;
   localparam int NARROW_START_BITS = 8;
   localparam int BUF_BYTES = 264;
   localparam logic [8:0] LAST_POS_WIDE = 9'h107;
   localparam logic [8:0] LAST_POS_NARROW = 9'h0FF;
   localparam logic PAGE_264_DEFAULT = 1'b0;
   // ==========================================================
   // Timing
   localparam int SYS_PERIOD_NS = 10;
   localparam int SYS_CLK_MHZ = 1000 / SYS_PERIOD_NS;
   localparam int ERASE_PROGRAM_TIME_MAX_US = 20;
   localparam int PROGRAM_TIME_MAX_US = 10;
   localparam int EP_CYC = ERASE_PROGRAM_TIME_MAX_US * SYS_CLK_MHZ;
   localparam int PROG_CYC = PROGRAM_TIME_MAX_US * SYS_CLK_MHZ;
   localparam int ERASE_CYC = EP_CYC - PROG_CYC;
   localparam int SCK_PERIOD_NS = 160;
   localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * SYS_PERIOD_NS);
   // ==========================================================
   // Program data path
   localparam int FIFO_DEPTH = 8;
   localparam int ARR_WORD_W = 17;
endpackage : fsb_pkg

/* File: hw/fsb_link_if.sv */
// Purpose: Serial link between the host controller and the flash end.
// Assumes: Host drives select, clock and data; device drives status levels.
// Notes: Busy and fail are status levels read by the host.
`timescale 1ns/1ps
interface fsb_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic busy;
   logic fail;
   modport dev (input cs_n, input sck, input si, output busy, output fail);
   modport host (output cs_n, output sck, output si, input busy, input fail);
endinterface : fsb_link_if

/* File: hw/fsb_fifo.sv */
// Purpose: Small FIFO with a registered output stage.
// Assumes: Single clock, synchronous active high reset.
// Notes: Holds DEPTH words in memory plus one in the output register.
`timescale 1ns/1ps
module fsb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // Drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   wire push = i_in_valid && o_in_ready;
   wire pop = (count != '0) && (!o_out_valid || i_out_ready);
   assign o_in_ready = (count != (PW + 1)'(DEPTH));
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         o_out_valid <= 1'b0;
         o_out_data <= '0;
      end else begin
         wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
         rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
         count <= count + (PW + 1)'(push) - (PW + 1)'(pop);
         if (pop) begin
            o_out_valid <= 1'b1;
            o_out_data <= mem[rd_ptr];
         end else if (i_out_ready) begin
            o_out_valid <= 1'b0;
         end
      end
   end
endmodule : fsb_fifo

/* File: hw/fsb_dev.sv */
// Purpose: Flash end: buffer loads and buffer-to-page commits.
// Assumes: Link pins are asynchronous and sampled; link clock is SPI mode 0.
// Notes: The main array sits outside; this end erases and streams pages to it.
// Functional notes
// - Buffer load opcodes 84h and 87h.
// - Wide load address: 15 ignored, 9 start.
// - Narrow load address: 16 ignored, 8 start.
// - Data bytes fill successive positions, wrapping.
// - Loading continues until select rises.
// - Erase commit opcodes 83h and 86h.
// - Wide commit: 3 ignored, 12 page, 9 ignored.
// - Narrow commit: 4 ignored, 12 page, 8 ignored.
// - Erase commit erases page, then programs buffer.
// - Busy flag set during erase or program.
// - Failed byte location sets the fail flag.
// - Plain commit opcodes 88h and 89h.
// - Host erases target page before plain commit.
// - Plain commit programs without erasing first.
// - Combined command opcodes 82h and 85h.
// - Wide combined: 3 ignored, 12 page, 9 start.
// - Narrow combined: 4 ignored, 12 page, 8 start.
// - Combined loads with wrap, then erases, programs.
`timescale 1ns/1ps
module fsb_dev (
   // Clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RESET,
   // Serial link
   fsb_link_if.dev link,
   // Configuration
   input wire logic I_PAGE_264,
   // Status
   output logic O_BUSY,
   output logic O_ERASE_PROGRAM_FAIL_FLAG,
   // Main array port
   output logic O_ARR_ERASE,
   output logic [fsb_pkg::PAGE_BITS-1:0] O_ARR_PAGE,
   output logic O_ARR_VALID,
   input wire logic I_ARR_READY,
   output logic [fsb_pkg::ARR_WORD_W-1:0] O_ARR_WORD,
   input wire logic I_ARR_FAIL
);
   import fsb_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ERASE = 4'b0010,
      ST_FEED = 4'b0100,
      ST_WAIT = 4'b1000
   } fsb_state_t;

   // ==========================================================
   // Pin synchronisers
   logic [2:0] cs_sync;
   logic [2:0] sck_sync;
   logic [1:0] si_sync;
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RESET) begin
         cs_sync <= 3'h7;
         sck_sync <= 3'h0;
         si_sync <= 2'h0;
      end else begin
         cs_sync <= {cs_sync[1:0], link.cs_n};
         sck_sync <= {sck_sync[1:0], link.sck};
         si_sync <= {si_sync[0], link.si};
      end
   end
   wire selected = !cs_sync[1];
   wire cs_rise = cs_sync[1] && !cs_sync[2];
   wire sck_rise = sck_sync[1] && !sck_sync[2] && selected;
   wire si_bit = si_sync[1];

   // ==========================================================
   // Command decode
   logic [7:0] shift;
   logic [2:0] bit_cnt;
   logic [2:0] byte_cnt;
   logic [7:0] opcode;
   logic [23:0] addr;
   logic [8:0] wr_pos;
   wire [7:0] next_shift = {shift[6:0], si_bit};
   wire byte_done = sck_rise && (bit_cnt == 3'h7);
   wire [23:0] next_addr = {addr[15:0], next_shift};
   wire op_load = (opcode == OP_LOAD_B1) || (opcode == OP_LOAD_B2);
   wire op_comb = (opcode == OP_LOAD_CMT_B1) || (opcode == OP_LOAD_CMT_B2);
   wire op_erase = (opcode == OP_CMT_ERASE_B1) || (opcode == OP_CMT_ERASE_B2);
   wire op_plain = (opcode == OP_CMT_NOERASE_B1) || (opcode == OP_CMT_NOERASE_B2);
   wire op_buf2 = (opcode == OP_LOAD_B2) || (opcode == OP_LOAD_CMT_B2)
      || (opcode == OP_CMT_ERASE_B2) || (opcode == OP_CMT_NOERASE_B2);
   wire [8:0] last_pos = I_PAGE_264 ? LAST_POS_WIDE : LAST_POS_NARROW;
   // Loads use the low bits as start position; the upper bits are ignored.
   wire [8:0] start_pos = I_PAGE_264 ? next_addr[WIDE_START_BITS-1:0]
      : {1'b0, next_addr[NARROW_START_BITS-1:0]};
   // Page index sits above the start or ignored field of the chosen layout.
   wire [PAGE_BITS-1:0] page_idx = I_PAGE_264
      ? addr[WIDE_PAGE_LSB +: PAGE_BITS]
      : addr[NARROW_PAGE_LSB +: PAGE_BITS];
   wire in_data = (byte_cnt == DATA_PHASE);
   wire buf_write = byte_done && in_data && (op_load || op_comb);
   // A commit needs a full address and must end on a byte boundary.
   wire commit_ok = in_data && (bit_cnt == 3'h0) && (op_erase || op_plain || op_comb);

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RESET || !selected) begin
         bit_cnt <= 3'h0;
         byte_cnt <= 3'h0;
         shift <= 8'h00;
      end else if (sck_rise) begin
         shift <= next_shift;
         bit_cnt <= bit_cnt + 3'h1;
         if (byte_done && !in_data) begin
            byte_cnt <= byte_cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RESET) begin
         opcode <= 8'h00;
         addr <= 24'h000000;
         wr_pos <= 9'h000;
      end else if (byte_done) begin
         if (byte_cnt == 3'h0) begin
            opcode <= next_shift;
         end else if (!in_data) begin
            addr <= next_addr;
            wr_pos <= start_pos;
         end else if (buf_write) begin
            wr_pos <= (wr_pos == last_pos) ? 9'h000 : wr_pos + 9'h001;
         end
      end
   end

   // ==========================================================
   // Page buffers
   logic [7:0] buf_mem [2][BUF_BYTES];
   logic sel;
   logic [8:0] rd_pos;
   // Writes run for as long as select is held low; nothing counts bytes.
   always_ff @(posedge I_SYS_CLK) begin
      if (buf_write) begin
         buf_mem[op_buf2][wr_pos] <= next_shift;
      end
   end
   wire [7:0] rd_byte = buf_mem[sel][rd_pos];

   // ==========================================================
   // Commit sequencer
   fsb_state_t state;
   fsb_state_t next_state;
   logic [15:0] timer;
   logic do_erase;
   logic fifo_ready;
   wire start = cs_rise && commit_ok && (state == ST_IDLE);
   wire feed_push = (state == ST_FEED);
   wire feed_last = feed_push && fifo_ready && (rd_pos == last_pos);
   wire drained = !O_ARR_VALID && fifo_ready;
   wire erase_done = (timer == 16'(ERASE_CYC - 1));
   wire prog_done = (timer >= 16'(PROG_CYC - 1)) && drained;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (start) begin
               next_state = (op_erase || op_comb) ? ST_ERASE : ST_FEED;
            end
         end
         ST_ERASE: begin
            if (erase_done) begin
               next_state = ST_FEED;
            end
         end
         ST_FEED: begin
            if (feed_last) begin
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (prog_done) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RESET) begin
         state <= ST_IDLE;
         timer <= 16'h0000;
         sel <= 1'b0;
         rd_pos <= 9'h000;
         do_erase <= 1'b0;
         O_ARR_PAGE <= '0;
      end else begin
         state <= next_state;
         timer <= (next_state != state) ? 16'h0000 : timer + 16'h0001;
         if (start) begin
            sel <= op_buf2;
            O_ARR_PAGE <= page_idx;
            do_erase <= op_erase || op_comb;
            rd_pos <= 9'h000;
         end else if (feed_push && fifo_ready) begin
            rd_pos <= rd_pos + 9'h001;
         end
      end
   end

   // ==========================================================
   // Status and array strobes
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RESET) begin
         O_BUSY <= 1'b0;
         O_ERASE_PROGRAM_FAIL_FLAG <= 1'b0;
         O_ARR_ERASE <= 1'b0;
      end else begin
         O_BUSY <= (next_state != ST_IDLE);
         O_ARR_ERASE <= start && (op_erase || op_comb);
         // A failure reported in the start cycle is ignored, since busy is still low then; start clears the flag.
         if (I_ARR_FAIL && O_BUSY) begin
            O_ERASE_PROGRAM_FAIL_FLAG <= 1'b1;
         end else if (start) begin
            O_ERASE_PROGRAM_FAIL_FLAG <= 1'b0;
         end
      end
   end
   assign link.busy = O_BUSY;
   assign link.fail = O_ERASE_PROGRAM_FAIL_FLAG;

   // The FIFO lets the array stall the page stream without losing bytes.
   fsb_fifo #(
      .WIDTH(ARR_WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(I_SYS_CLK),
      .i_reset(I_RESET),
      .i_in_valid(feed_push),
      .o_in_ready(fifo_ready),
      .i_in_data({rd_pos, rd_byte}),
      .o_out_valid(O_ARR_VALID),
      .i_out_ready(I_ARR_READY),
      .o_out_data(O_ARR_WORD)
   );
endmodule : fsb_dev

/* File: hw/fsb_host.sv */
// Purpose: Host end: sends load and commit commands over the serial link.
// Assumes: Mode 0 link; the link clock is divided down from the system clock.
// Notes: Commits and combined commands wait for the device to go idle.
`timescale 1ns/1ps
module fsb_host (
   // Clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RESET,
   // Serial link
   fsb_link_if.host link,
   // Command request
   input wire logic I_CMD_VALID,
   output logic O_CMD_READY,
   input wire logic [7:0] I_CMD_OP,
   input wire logic [23:0] I_CMD_ADDR,
   input wire logic [9:0] I_CMD_LEN,
   // Data stream
   input wire logic I_DATA_VALID,
   output logic O_DATA_READY,
   input wire logic [7:0] I_DATA,
   // Completion and status
   output logic O_DONE,
   output logic O_DEV_BUSY,
   output logic O_DEV_FAIL
);
   import fsb_pkg::*;

   typedef enum logic [4:0] {
      H_IDLE = 5'b00001,
      H_WAIT = 5'b00010,
      H_LOAD = 5'b00100,
      H_SHIFT = 5'b01000,
      H_END = 5'b10000
   } fsb_hstate_t;

   fsb_hstate_t state;
   logic [1:0] busy_sync;
   logic [1:0] fail_sync;
   logic [7:0] op;
   logic [23:0] addr;
   logic [10:0] total;
   logic [10:0] idx;
   logic [7:0] tx;
   logic [2:0] bit_cnt;
   logic [7:0] div;
   logic cs_n;
   logic sck;

   wire is_load = (op == OP_LOAD_B1) || (op == OP_LOAD_B2);
   wire half_end = (div == 8'(SCK_HALF_CYC - 1));
   wire in_data = (idx >= 11'(ADDR_BYTES + 1));
   wire take = O_DATA_READY && I_DATA_VALID;
   wire [7:0] hdr_byte = (idx == 11'h000) ? op
      : (idx == 11'h001) ? addr[23:16]
      : (idx == 11'h002) ? addr[15:8] : addr[7:0];
   wire last_bit = half_end && sck && (bit_cnt == 3'h7);

   // ==========================================================
   // Status synchronisers
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RESET) begin
         busy_sync <= 2'h0;
         fail_sync <= 2'h0;
      end else begin
         busy_sync <= {busy_sync[0], link.busy};
         fail_sync <= {fail_sync[0], link.fail};
      end
   end
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RESET) begin
         O_DEV_BUSY <= 1'b0;
         O_DEV_FAIL <= 1'b0;
      end else begin
         O_DEV_BUSY <= busy_sync[1];
         O_DEV_FAIL <= fail_sync[1];
      end
   end

   // ==========================================================
   // Command sequencer and clock divider
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RESET) begin
         state <= H_IDLE;
         O_CMD_READY <= 1'b1;
         O_DATA_READY <= 1'b0;
         O_DONE <= 1'b0;
         op <= 8'h00;
         addr <= 24'h000000;
         total <= 11'h000;
         idx <= 11'h000;
         tx <= 8'h00;
         bit_cnt <= 3'h0;
         div <= 8'h00;
         cs_n <= 1'b1;
         sck <= 1'b0;
      end else begin
         O_DONE <= 1'b0;
         unique case (state)
            H_IDLE: begin
               if (I_CMD_VALID) begin
                  O_CMD_READY <= 1'b0;
                  op <= I_CMD_OP;
                  addr <= I_CMD_ADDR;
                  total <= 11'(I_CMD_LEN) + 11'(ADDR_BYTES + 1);
                  idx <= 11'h000;
                  state <= H_WAIT;
               end
            end
            H_WAIT: begin
               // Loads may overlap a program of the other buffer.
               if (is_load || !busy_sync[1]) begin
                  state <= H_LOAD;
               end
            end
            H_LOAD: begin
               div <= 8'h00;
               bit_cnt <= 3'h0;
               if (!in_data) begin
                  cs_n <= 1'b0;
                  tx <= hdr_byte;
                  state <= H_SHIFT;
               end else if (take) begin
                  O_DATA_READY <= 1'b0;
                  tx <= I_DATA;
                  state <= H_SHIFT;
               end else begin
                  O_DATA_READY <= 1'b1;
               end
            end
            H_SHIFT: begin
               div <= half_end ? 8'h00 : div + 8'h01;
               if (half_end) begin
                  sck <= !sck;
                  if (sck) begin
                     tx <= {tx[6:0], 1'b0};
                     bit_cnt <= bit_cnt + 3'h1;
                  end
               end
               if (last_bit) begin
                  idx <= idx + 11'h001;
                  state <= (idx + 11'h001 == total) ? H_END : H_LOAD;
               end
            end
            H_END: begin
               div <= half_end ? 8'h00 : div + 8'h01;
               if (half_end) begin
                  if (!cs_n) begin
                     cs_n <= 1'b1;
                  end else begin
                     O_DONE <= 1'b1;
                     O_CMD_READY <= 1'b1;
                     state <= H_IDLE;
                  end
               end
            end
            default: begin
               state <= H_IDLE;
            end
         endcase
      end
   end

   assign link.cs_n = cs_n;
   assign link.sck = sck;
   assign link.si = tx[7];
endmodule : fsb_host

/* File: tb/fsb_link_assertions.sv */
// Purpose: Timing checks on the serial link between host and flash ends.
// Assumes: One system clock domain; synchronous active high reset.
// Notes: Watches only the interface signals.
`timescale 1ns/1ps
module fsb_link_assertions (
   // Clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RESET,
   // Link signals
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic busy,
   input wire logic fail
);
   import fsb_pkg::*;
   int busy_len;
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RESET);
   // ==========================================================
   // Helper counter
   // Counts cycles of one busy interval so its length can be bounded.
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RESET || !busy) busy_len <= 0;
      else busy_len <= busy_len + 1;
   end
   // ==========================================================
   // Link framing
   a_sck_idle_low: assert property (cs_n |-> !sck)
      else $error("link clock not low outside a frame");
   a_sck_in_frame: assert property ($rose(sck) |-> !cs_n)
      else $error("link clock edge outside a frame");
   a_sck_high_time: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
      else $error("link clock high phase not eight cycles");
   a_si_held_high: assert property (sck |-> $stable(si))
      else $error("serial data moved while link clock high");
   a_cs_rise_clean: assert property ($rose(cs_n) |-> !sck && !$past(sck))
      else $error("select rose in mid bit");
   // ==========================================================
   // Status
   a_busy_after_cs: assert property ($rose(busy) |-> cs_n && !$past(cs_n, 8))
      else $error("busy rose without a frame ending");
   a_busy_min_time: assert property ($fell(busy) |-> busy_len >= PROG_CYC)
      else $error("busy shorter than the program time");
   a_busy_max_time: assert property (busy |-> busy_len < 20000)
      else $error("busy never ends");
   a_fail_in_busy: assert property ($rose(fail) |-> $past(busy))
      else $error("fail flag rose outside an operation");
endmodule : fsb_link_assertions

/* File: tb/serial_flash_buffer_program_cmds_tb_top.sv */
// Purpose: Host and flash ends joined; loads, commits and status checked.
// Assumes: Array port modelled by the bench with optional stalls.
// Notes: Ignored address bits are sent as ones to show they are ignored.
`timescale 1ns/1ps
module serial_flash_buffer_program_cmds_tb_top;
   import fsb_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic page_264 = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   logic [7:0] cmd_op = 8'h00;
   logic [23:0] cmd_addr = 24'h000000;
   logic [9:0] cmd_len = 10'h000;
   logic data_valid = 1'b0;
   logic data_ready;
   logic [7:0] data_byte = 8'h00;
   logic done;
   logic dev_busy;
   logic dev_fail;
   logic busy;
   logic erase_program_fail_flag;
   logic arr_erase;
   logic arr_valid;
   logic arr_ready = 1'b1;
   logic arr_fail = 1'b0;
   logic [11:0] arr_page;
   logic [16:0] arr_word;
   logic stall = 1'b0;
   logic inject = 1'b0;
   logic [7:0] got [0:511];
   int word_count = 0;
   int order_err = 0;
   int erase_cnt = 0;
   int cyc = 0;
   int fail_count = 0;
   int checked = 0;
   always #5 sys_clk = ~sys_clk;
   // ==========================================================
   // Design
   fsb_link_if u_fsb_link_if ();
   fsb_host u_fsb_host (.I_SYS_CLK(sys_clk), .I_RESET(reset), .link(u_fsb_link_if.host),
      .I_CMD_VALID(cmd_valid), .O_CMD_READY(cmd_ready), .I_CMD_OP(cmd_op),
      .I_CMD_ADDR(cmd_addr), .I_CMD_LEN(cmd_len), .I_DATA_VALID(data_valid),
      .O_DATA_READY(data_ready), .I_DATA(data_byte), .O_DONE(done),
      .O_DEV_BUSY(dev_busy), .O_DEV_FAIL(dev_fail));
   fsb_dev u_fsb_dev (.I_SYS_CLK(sys_clk), .I_RESET(reset), .link(u_fsb_link_if.dev),
      .I_PAGE_264(page_264), .O_BUSY(busy),
      .O_ERASE_PROGRAM_FAIL_FLAG(erase_program_fail_flag), .O_ARR_ERASE(arr_erase),
      .O_ARR_PAGE(arr_page), .O_ARR_VALID(arr_valid), .I_ARR_READY(arr_ready),
      .O_ARR_WORD(arr_word), .I_ARR_FAIL(arr_fail));
   fsb_link_assertions u_fsb_link_assertions (.I_SYS_CLK(sys_clk), .I_RESET(reset),
      .cs_n(u_fsb_link_if.cs_n), .sck(u_fsb_link_if.sck), .si(u_fsb_link_if.si),
      .busy(u_fsb_link_if.busy), .fail(u_fsb_link_if.fail));
   // ==========================================================
   // Array model
   // Stalls half the time so the FIFO fills, refuses and later drains.
   always @(negedge sys_clk) begin
      arr_ready <= !(stall && cyc[5]);
      arr_fail <= inject && (word_count == 5);
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (arr_erase) erase_cnt <= erase_cnt + 1;
      if (arr_valid && arr_ready) begin
         got[arr_word[16:8]] <= arr_word[7:0];
         if (arr_word[16:8] !== word_count[8:0]) order_err <= order_err + 1;
         word_count <= word_count + 1;
      end
   end
   // ==========================================================
   // Shared tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      if (fail_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task automatic time_out();
      check("wait bound", 32'h1, 32'h0);
      give_verdict();
   endtask : time_out
   task automatic send(input logic [7:0] op, input logic [23:0] addr, input int len,
         input logic [31:0] d);
      int idx;
      int n;
      logic taken;
      idx = 0;
      n = 0;
      taken = 1'b0;
      @(negedge sys_clk);
      cmd_op = op;
      cmd_addr = addr;
      cmd_len = len[9:0];
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1 && n < 20000) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      while (done !== 1'b1 && n < 20000) begin
         if (taken) idx++;
         data_valid = (idx < len);
         data_byte = d[31 - 8 * (idx % 4) -: 8];
         taken = data_valid && data_ready;
         @(negedge sys_clk);
         n++;
      end
      data_valid = 1'b0;
      if (n >= 20000) time_out();
   endtask : send
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 20000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 20000) time_out();
   endtask : wait_idle
   task automatic commit(input logic [7:0] op, input logic [23:0] addr, input int len,
         input logic [31:0] d, input logic [11:0] pg, input logic er, input int nw);
      word_count = 0;
      order_err = 0;
      erase_cnt = 0;
      send(op, addr, len, d);
      check("host busy", {31'h0, dev_busy}, 32'h1);
      wait_idle();
      repeat (4) @(negedge sys_clk);
      check("host busy clear", {31'h0, dev_busy}, 32'h0);
      check("erase pulses", erase_cnt, {31'h0, er});
      check("page", {20'h0, arr_page}, {20'h0, pg});
      check("word count", word_count, nw);
      check("word order", order_err, 32'h0);
   endtask : commit
   // ==========================================================
   // Scenarios
   task automatic t_narrow_wrap();
      page_264 = 1'b0;
      send(OP_LOAD_B1, 24'hFFFFFE, 4, 32'hA1B2C3D4);
      check("busy after load", {31'h0, busy}, 32'h0);
      commit(OP_CMT_ERASE_B1, 24'hF123FF, 0, 32'h0, 12'h123, 1'b1, 256);
      check("pos 0FE", got[9'h0FE], 8'hA1);
      check("pos 0FF", got[9'h0FF], 8'hB2);
      check("pos 000", got[9'h000], 8'hC3);
      check("pos 001", got[9'h001], 8'hD4);
   endtask : t_narrow_wrap
   task automatic t_wide_stall();
      page_264 = 1'b1;
      stall = 1'b1;
      send(OP_LOAD_B2, 24'hFFFF07, 2, 32'h11220000);
      // Plain commits go to pages that no earlier commit touched, so they are still erased.
      commit(OP_CMT_NOERASE_B2, 24'hF579FF, 0, 32'h0, 12'hABC, 1'b0, 264);
      check("pos 107", got[9'h107], 8'h11);
      check("pos 000", got[9'h000], 8'h22);
      commit(OP_LOAD_CMT_B2, 24'hE01305, 2, 32'h77880000, 12'h009, 1'b1, 264);
      check("pos 105", got[9'h105], 8'h77);
      check("pos 106", got[9'h106], 8'h88);
      stall = 1'b0;
   endtask : t_wide_stall
   task automatic t_combined_fail();
      page_264 = 1'b0;
      inject = 1'b1;
      commit(OP_LOAD_CMT_B1, 24'hF00510, 3, 32'h5AA53C00, 12'h005, 1'b1, 256);
      inject = 1'b0;
      check("pos 010", got[9'h010], 8'h5A);
      check("pos 012", got[9'h012], 8'h3C);
      check("fail flag", {31'h0, erase_program_fail_flag}, 32'h1);
      check("host fail", {31'h0, dev_fail}, 32'h1);
      commit(OP_CMT_ERASE_B2, 24'hF007FF, 0, 32'h0, 12'h007, 1'b1, 256);
      check("second buffer kept", got[9'h000], 8'h22);
      check("fail cleared", {31'h0, erase_program_fail_flag}, 32'h0);
      commit(OP_CMT_NOERASE_B1, 24'hF008FF, 0, 32'h0, 12'h008, 1'b0, 256);
      check("first buffer kept", got[9'h001], 8'hD4);
   endtask : t_combined_fail
   // ==========================================================
   // Main sequence
   initial begin
      repeat (5) @(negedge sys_clk);
      reset = 1'b0;
      repeat (3) @(negedge sys_clk);
      t_narrow_wrap();
      t_wide_stall();
      t_combined_fail();
      give_verdict();
   end
endmodule : serial_flash_buffer_program_cmds_tb_top
